// *** shared/pdcw_pkg.sv ***
// constants for the serial configuration receiver and word 0 fields
package pdcw_pkg;
    localparam int          WORD_BITS      = 32;
    localparam int          SEL_LO         = 0;
    localparam int          SEL_HI         = 1;
    localparam logic [1:0]  SEL_WORD0      = 2'h0;
    localparam int          REF_DIV_LSB    = 2;
    localparam int          REF_DIV_MSB    = 11;
    localparam int          FB_DIV_LSB     = 12;
    localparam int          FB_DIV_MSB     = 23;
    localparam int          REF_DLY_LSB    = 24;
    localparam int          REF_DLY_MSB    = 26;
    localparam int          FB_DLY_LSB     = 27;
    localparam int          FB_DLY_MSB     = 29;
    localparam int          AUTO_SEL_BIT   = 30;
    localparam int          DET_DIS_BIT    = 31;
    // reset values of the four words; words 1..3 are opaque here
    localparam logic [31:0] WORD0_RESET    = 32'h0007_F1FC;
    localparam logic [31:0] WORD1_RESET    = 32'h0000_007D;
    localparam logic [31:0] WORD2_RESET    = 32'h0000_0002;
    localparam logic [31:0] WORD3_RESET    = 32'h0000_0003;
    localparam logic [5:0]  BIT_CNT_RESET  = 6'h00;
endpackage : pdcw_pkg

// *** core/pdcw_sync.sv ***
// three-stage synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module pdcw_sync (
    // clock, reset and enable
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // asynchronous input and filtered level
    input  wire logic din,
    output logic      dout
);
    logic s1_reg, s2_reg, s3_reg, out_reg;
    logic s1_next, s2_next, s3_next, out_next;

    // shift chain; output changes only when stages 2 and 3 agree
    always_comb begin
        s1_next  = din;
        s2_next  = s1_reg;
        s3_next  = s2_reg;
        out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg  <= 1'b0;
            s2_reg  <= 1'b0;
            s3_reg  <= 1'b0;
            out_reg <= 1'b0;
        end else if (ce) begin
            s1_reg  <= s1_next;
            s2_reg  <= s2_next;
            s3_reg  <= s3_next;
            out_reg <= out_next;
        end
    end

    assign dout = out_reg;
endmodule : pdcw_sync

// *** core/pdcw_top.sv ***
// serial write path and divider configuration word of the clock synchroniser
// Operation
// - each transfer is thirty-two bits, MSB first
// - shift on rising serial clock while latch low
// - latch rising edge commits the shifted word
// - two lowest bits select one of four registers
// - write only, no read-back or acknowledge
// - defaults after reset and while power-down asserted
// - reference divider bits 2..11, default 7Fh
// - feedback divider bits 12..23, default 7Fh
// - reference delay code bits 24..26, default zero
// - feedback delay code bits 27..29, default zero
// - bit 30 selects automatic reference selection
// - bit 31 disables reference frequency detection
// - detection disabled forces reference status high
// - detection enabled, slow reference drives status low
`timescale 1ns/1ps
module pdcw_top (
    // system clock, reset and enable
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // serial configuration link (link clock domain), inputs only
    input  wire logic        serial_cfg_clk,
    input  wire logic        serial_cfg_data,
    input  wire logic        serial_cfg_latch,
    // device control pins
    input  wire logic        power_down_n,
    input  wire logic        ref_freq_ok,
    // word 0 fields and reference status
    output logic [9:0]       reference_divider_value,
    output logic [11:0]      feedback_divider_value,
    output logic [2:0]       reference_delay_code,
    output logic [2:0]       feedback_delay_code,
    output logic             ref_select_automatic,
    output logic             ref_freq_detect_disable,
    output logic             ref_status,
    // other three words, raw
    output logic [31:0]      word1_value,
    output logic [31:0]      word2_value,
    output logic [31:0]      word3_value
);
    // reset release through two flops
    logic rst_a_reg, rst_b_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_a_reg <= 1'b0;
            rst_b_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_b_reg <= rst_a_reg;
        end
    end
    logic rst_n;
    assign rst_n = rst_b_reg;

    // link domain: shifter clocked by serial clock, frozen while latch high
    logic [31:0] shift_reg, shift_next;
    always_comb begin
        // last 32 bits shifted in form the word, msb first
        shift_next = {shift_reg[30:0], serial_cfg_data};
        if (serial_cfg_latch) begin
            shift_next = shift_reg;
        end
    end
    always_ff @(posedge serial_cfg_clk) begin
        shift_reg <= shift_next;
    end

    // latch crosses as a level, inverted so the reset value matches the idle high pin
    logic latch_low_s;
    logic latch_s;
    pdcw_sync u_latch_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (!serial_cfg_latch),
        .dout  (latch_low_s)
    );
    assign latch_s = !latch_low_s; // no false rising edge after reset
    logic pd_s;
    pdcw_sync u_pd_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (power_down_n),
        .dout  (pd_s)
    );
    logic ref_ok_s;
    pdcw_sync u_ref_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .din   (ref_freq_ok),
        .dout  (ref_ok_s)
    );

    // rising latch samples the frozen shifter (held until next falling latch)
    logic        latch_d_reg, latch_d_next;
    logic        commit;
    logic [31:0] word0_reg, word0_next;
    logic [31:0] word1_reg, word1_next;
    logic [31:0] word2_reg, word2_next;
    logic [31:0] word3_reg, word3_next;
    logic        stat_reg, stat_next;
    always_comb begin
        latch_d_next = latch_s;
        commit       = latch_s && !latch_d_reg;
        word0_next   = word0_reg;
        word1_next   = word1_reg;
        word2_next   = word2_reg;
        word3_next   = word3_reg;
        if (!pd_s) begin
            // power-down restores defaults
            word0_next = pdcw_pkg::WORD0_RESET;
            word1_next = pdcw_pkg::WORD1_RESET;
            word2_next = pdcw_pkg::WORD2_RESET;
            word3_next = pdcw_pkg::WORD3_RESET;
        end else if (commit) begin
            unique case ({shift_reg[pdcw_pkg::SEL_HI], shift_reg[pdcw_pkg::SEL_LO]})
                pdcw_pkg::SEL_WORD0: word0_next = shift_reg;
                2'h1:                word1_next = shift_reg;
                2'h2:                word2_next = shift_reg;
                2'h3:                word3_next = shift_reg;
            endcase
        end
        // reference status output
        stat_next = word0_reg[pdcw_pkg::DET_DIS_BIT] ? 1'b1 : ref_ok_s;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_d_reg <= 1'b1;
            word0_reg   <= pdcw_pkg::WORD0_RESET;
            word1_reg   <= pdcw_pkg::WORD1_RESET;
            word2_reg   <= pdcw_pkg::WORD2_RESET;
            word3_reg   <= pdcw_pkg::WORD3_RESET;
            stat_reg    <= 1'b0;
        end else if (ce) begin
            latch_d_reg <= latch_d_next;
            word0_reg   <= word0_next;
            word1_reg   <= word1_next;
            word2_reg   <= word2_next;
            word3_reg   <= word3_next;
            stat_reg    <= stat_next;
        end
    end

    // field outputs straight from the word registers
    assign reference_divider_value = word0_reg[pdcw_pkg::REF_DIV_MSB:pdcw_pkg::REF_DIV_LSB];
    assign feedback_divider_value  = word0_reg[pdcw_pkg::FB_DIV_MSB:pdcw_pkg::FB_DIV_LSB];
    assign reference_delay_code    = word0_reg[pdcw_pkg::REF_DLY_MSB:pdcw_pkg::REF_DLY_LSB];
    assign feedback_delay_code     = word0_reg[pdcw_pkg::FB_DLY_MSB:pdcw_pkg::FB_DLY_LSB];
    assign ref_select_automatic    = word0_reg[pdcw_pkg::AUTO_SEL_BIT];
    assign ref_freq_detect_disable = word0_reg[pdcw_pkg::DET_DIS_BIT];
    assign ref_status              = stat_reg;
    assign word1_value             = word1_reg;
    assign word2_value             = word2_reg;
    assign word3_value             = word3_reg;

    // checks
    sequence s_latch_rise;
        ce && pd_s && latch_s && !latch_d_reg;
    endsequence
    sequence s_sel_word0;
        shift_reg[1:0] == pdcw_pkg::SEL_WORD0;
    endsequence
    property p_commit_word0;
        @(posedge clk) disable iff (!rst_n)
        (s_latch_rise and s_sel_word0) |=> word0_reg == $past(shift_reg, 1);
    endproperty
    a_commit_word0: assert property (p_commit_word0) else $error("word 0 not committed");
    property p_sel_other;
        @(posedge clk) disable iff (!rst_n)
        (ce && pd_s && shift_reg[1:0] != pdcw_pkg::SEL_WORD0) |=> $stable(word0_reg);
    endproperty
    a_sel_other: assert property (p_sel_other) else $error("word 0 hit by other selector");
    property p_pd_default;
        @(posedge clk) disable iff (!rst_n)
        (ce && !pd_s) |=> word0_reg == pdcw_pkg::WORD0_RESET && word3_reg == pdcw_pkg::WORD3_RESET;
    endproperty
    a_pd_default: assert property (p_pd_default) else $error("defaults not restored");
    property p_hold_no_latch;
        @(posedge clk) disable iff (!rst_n)
        (ce && !(latch_s && !latch_d_reg) && pd_s) |=> $stable(word0_reg);
    endproperty
    a_hold_no_latch: assert property (p_hold_no_latch) else $error("word changed mid transfer");
    property p_det_dis;
        @(posedge clk) disable iff (!rst_n)
        (ce && word0_reg[pdcw_pkg::DET_DIS_BIT]) |=> ref_status;
    endproperty
    a_det_dis: assert property (p_det_dis) else $error("status not forced high");
    property p_det_low;
        @(posedge clk) disable iff (!rst_n)
        (ce && !word0_reg[pdcw_pkg::DET_DIS_BIT] && !ref_ok_s) |=> !ref_status;
    endproperty
    a_det_low: assert property (p_det_low) else $error("status not low on slow ref");
    // field outputs against the shifted bits; shifter is frozen while latch high
    property p_fields;
        @(posedge clk) disable iff (!rst_n)
        (s_latch_rise and s_sel_word0) |=>
            reference_divider_value == shift_reg[11:2] && feedback_delay_code == shift_reg[29:27];
    endproperty
    a_fields: assert property (p_fields) else $error("field mapping wrong");
    property p_fb_field;
        @(posedge clk) disable iff (!rst_n)
        (s_latch_rise and s_sel_word0) |=>
            feedback_divider_value == shift_reg[23:12] && reference_delay_code == shift_reg[26:24]
            && ref_select_automatic == shift_reg[30] && ref_freq_detect_disable == shift_reg[31];
    endproperty
    a_fb_field: assert property (p_fb_field) else $error("feedback field mapping wrong");
endmodule : pdcw_top

// *** dv/pdcw_host_model.sv ***
// host model driving the three-wire serial write link
`timescale 1ns/1ps
module pdcw_host_model (
    // serial write link
    output logic serial_cfg_clk,
    output logic serial_cfg_data,
    output logic serial_cfg_latch
);
    // idle link: latch high, link clock stands still
    initial begin
        serial_cfg_clk   = 1'b0;
        serial_cfg_data  = 1'b1;
        serial_cfg_latch = 1'b1;
    end
    // one whole word, msb first, 30 ns link clock, no answer awaited
    task send(input logic [31:0] w);
        integer i;
        serial_cfg_latch = 1'b0;
        #16.3; // first edge skewed against the system clock
        for (i = 31; i >= 0; i--) begin
            serial_cfg_data = w[i];
            #15 serial_cfg_clk = 1'b1;
            #15 serial_cfg_clk = 1'b0;
        end
        serial_cfg_data = ~serial_cfg_data; // released line shows no stale bit
        #15 serial_cfg_latch = 1'b1;
        #60; // quiet link while the word is committed
    endtask : send
endmodule : pdcw_host_model

// *** dv/test_pll_divider_config_word0.sv ***
// self-checking bench for the serial divider configuration word
`timescale 1ns/1ps
module test_pll_divider_config_word0;
    // clock, reset and pins
    logic        clk;
    logic        resetn;
    logic        ce;
    logic        power_down_n;
    logic        ref_freq_ok;
    logic        serial_cfg_clk;
    logic        serial_cfg_data;
    logic        serial_cfg_latch;
    logic [9:0]  reference_divider_value;
    logic [11:0] feedback_divider_value;
    logic [2:0]  reference_delay_code;
    logic [2:0]  feedback_delay_code;
    logic        ref_select_automatic;
    logic        ref_freq_detect_disable;
    logic        ref_status;
    logic [31:0] word1_value;
    logic [31:0] word2_value;
    logic [31:0] word3_value;
    logic [31:0] w0_seen;
    int          num_errors;
    int          total_checks;
    int          cycles;
    // word 0 under test: detect off, auto select, delays 5/2, dividers 2A5h/A5Ch
    localparam logic [31:0] W0_A   = {1'b1, 1'b1, 3'h2, 3'h5, 12'hA5C, 10'h2A5, 2'h0};
    localparam logic [31:0] W0_B   = {1'b0, 1'b0, 3'h7, 3'h0, 12'h001, 10'h3FF, 2'h0};
    localparam logic [31:0] W0_DEF = {1'b0, 1'b0, 3'h0, 3'h0, 12'h07F, 10'h07F, 2'h0};
    // fields reassembled into word order
    assign w0_seen = {ref_freq_detect_disable, ref_select_automatic, feedback_delay_code,
                      reference_delay_code, feedback_divider_value, reference_divider_value, 2'h0};
    // device and host
    pdcw_top u_dut (
        .clk(clk), .resetn(resetn), .ce(ce),
        .serial_cfg_clk(serial_cfg_clk), .serial_cfg_data(serial_cfg_data), .serial_cfg_latch(serial_cfg_latch),
        .power_down_n(power_down_n), .ref_freq_ok(ref_freq_ok),
        .reference_divider_value(reference_divider_value), .feedback_divider_value(feedback_divider_value),
        .reference_delay_code(reference_delay_code), .feedback_delay_code(feedback_delay_code),
        .ref_select_automatic(ref_select_automatic), .ref_freq_detect_disable(ref_freq_detect_disable),
        .ref_status(ref_status), .word1_value(word1_value), .word2_value(word2_value), .word3_value(word3_value)
    );
    pdcw_host_model u_host (
        .serial_cfg_clk(serial_cfg_clk), .serial_cfg_data(serial_cfg_data), .serial_cfg_latch(serial_cfg_latch)
    );
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // hang guard
    initial cycles = 0;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            $display("[ERR] timeout expected end seen hang");
            finish_test();
        end
    end
    // compare and count
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    // commit takes 4-5 cycles after latch rise
    task settle;
        repeat (10) @(posedge clk);
        #1;
    endtask : settle
    // defaults after reset and after power-down
    task t_defaults(input string tag);
        check("word0", W0_DEF, w0_seen);
        check("word1", pdcw_pkg::WORD1_RESET, word1_value);
        check("word2", pdcw_pkg::WORD2_RESET, word2_value);
        check("word3", pdcw_pkg::WORD3_RESET, word3_value);
        $display("test defaults %s done", tag);
    endtask : t_defaults
    // word 0 fields, nothing seen mid-transfer, detect off forces status high
    task t_word0;
        fork
            u_host.send(W0_A);
            begin
                repeat (100) @(posedge clk);
                #1;
                check("word0 mid", W0_DEF, w0_seen);
            end
        join
        settle();
        check("word0", W0_A, w0_seen);
        check("status forced", 32'h1, {31'h0, ref_status});
        $display("test word0 done");
    endtask : t_word0
    // detect on: status follows reference presence
    task t_detect;
        u_host.send(W0_B);
        settle();
        check("word0 b", W0_B, w0_seen);
        check("status low", 32'h0, {31'h0, ref_status});
        ref_freq_ok = 1'b1;
        settle();
        check("status high", 32'h1, {31'h0, ref_status});
        $display("test detect done");
    endtask : t_detect
    // selector picks words 1..3, word 0 untouched
    task t_others;
        logic [31:0] w;
        logic [31:0] got;
        for (int k = 1; k < 4; k++) begin
            w = {4'h5, 4'(k), 22'h2AAAAA, 2'(k)};
            u_host.send(w);
            settle();
            got = (k == 1) ? word1_value : (k == 2) ? word2_value : word3_value;
            check("word sel", w, got);
            check("word0 kept", W0_B, w0_seen);
        end
        $display("test others done");
    endtask : t_others
    // power-down restores all defaults
    task t_power_down;
        power_down_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 power_down_n = 1'b1;
        settle();
        t_defaults("power down");
    endtask : t_power_down
    // clock enable low freezes synchronisers: a power-down pulse is not seen
    task t_freeze;
        ce           = 1'b0;
        power_down_n = 1'b0;
        repeat (10) @(posedge clk);
        #1 power_down_n = 1'b1;
        repeat (10) @(posedge clk);
        #1 ce = 1'b1;
        settle();
        check("word0 frozen", W0_B, w0_seen);
        $display("test freeze done");
    endtask : t_freeze
    // reset in mid-run restores defaults after a word was written
    task t_reset_mid;
        u_host.send(W0_A);
        settle();
        check("word0 pre reset", W0_A, w0_seen);
        resetn = 1'b0;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        t_defaults("mid reset");
    endtask : t_reset_mid
    // verdict and end of run
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // main sequence
    initial begin
        num_errors   = 0;
        total_checks = 0;
        resetn       = 1'b0;
        ce           = 1'b1;
        power_down_n = 1'b1;
        ref_freq_ok  = 1'b0;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        t_defaults("reset");
        check("status reset", 32'h0, {31'h0, ref_status});
        t_word0();
        t_detect();
        t_others();
        t_freeze();
        t_power_down();
        t_reset_mid();
        finish_test();
    end
endmodule : test_pll_divider_config_word0
